// ---- pkg/swwd_pkg.sv ----
// constants, types and helpers of the supervisor window watchdog
package swwd_pkg;

    localparam int CLK_KHZ          = 200000;
    localparam int RST_HOLD_MS      = 200;
    localparam int WIN_LOW_FLOAT_MS = 800;
    localparam int WIN_UP_FLOAT_MS  = 1600;
    localparam int WIN_LOW_PULL_US  = 1850;
    localparam int WIN_UP_PULL_US   = 11000;
    localparam int SETTLE_US        = 150;
    localparam int CLS_EVAL_US      = 381;
    localparam int CLS_FLOAT_US     = 50;
    localparam int CAP_UPPER_RST_MS = 63;

    // the settle time rounds up, every other divided time rounds down
    localparam int RST_HOLD_CYC  = RST_HOLD_MS * CLK_KHZ;
    localparam int LOW_FLOAT_CYC = WIN_LOW_FLOAT_MS * CLK_KHZ;
    localparam int UP_FLOAT_CYC  = WIN_UP_FLOAT_MS * CLK_KHZ;
    localparam int LOW_PULL_CYC  = (WIN_LOW_PULL_US * CLK_KHZ) / 1000;
    // product taken in megahertz so that it stays inside the int range
    localparam int UP_PULL_CYC   = WIN_UP_PULL_US * (CLK_KHZ / 1000);
    localparam int SETTLE_CYC    = (SETTLE_US * CLK_KHZ + 999) / 1000;
    localparam int CLS_EVAL_CYC  = (CLS_EVAL_US * CLK_KHZ) / 1000;
    localparam int CLS_FLOAT_CYC = (CLS_FLOAT_US * CLK_KHZ) / 1000;
    localparam logic [31:0] CAP_UPPER_RST = 32'(CAP_UPPER_RST_MS * CLK_KHZ);

    localparam logic [11:0] REG_STATUS      = 12'h000;
    localparam logic [11:0] REG_CAP_UPPER   = 12'h004;
    localparam logic [11:0] REG_FAULT_COUNT = 12'h008;

    localparam int ST_RESET_BIT  = 0;
    localparam int ST_FAULT_BIT  = 1;
    localparam int ST_MODE_LSB   = 2;
    localparam int ST_CLS_BIT    = 4;
    localparam int ST_RUN_BIT    = 5;
    localparam int ST_RPIN_BIT   = 6;
    localparam int ST_FPIN_BIT   = 7;

    typedef enum logic [1:0] {
        MODE_FLOAT,
        MODE_PULLUP,
        MODE_CAP
    } swwd_mode_type;

    typedef enum {CLS_IDLE, CLS_PROBE, CLS_CHARGE, CLS_DONE} swwd_cls_type;

    typedef enum {WD_OFF, WD_SETUP, WD_FIRST, WD_RUN, WD_FAULT} swwd_wd_type;

    typedef struct packed {
        logic [31:0] lower;
        logic [31:0] upper;
    } swwd_window_type;

    function automatic swwd_window_type swwd_window(
        input swwd_mode_type mode,
        input logic [31:0]   cap_upper,
        input logic [31:0]   low_float,
        input logic [31:0]   up_float,
        input logic [31:0]   low_pull,
        input logic [31:0]   up_pull
    );
        swwd_window_type w;
        case (mode)
            MODE_FLOAT: begin
                w.lower = low_float;
                w.upper = up_float;
            end
            MODE_PULLUP: begin
                w.lower = low_pull;
                w.upper = up_pull;
            end
            default: begin
                w.lower = {1'b0, cap_upper[31:1]};
                w.upper = cap_upper;
            end
        endcase
        return w;
    endfunction : swwd_window

endpackage : swwd_pkg

// ---- tb/swwd_host.sv ----
// host model: toggles the kick line with a set spacing between falls
`timescale 1ns/100ps
`default_nettype none
module swwd_host (
    input  wire logic        hclk,    // bus clock
    input  wire logic        hresetn, // async reset, low
    input  wire logic        go,      // kicking on
    input  wire logic [15:0] gap,     // cycles between falls
    output logic             kick     // kick line
);
    logic [15:0] cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt  <= 16'h0000;
            kick <= 1'b1;
        end else if (!go) begin
            cnt <= 16'h0000;
        end else if (cnt == gap - 16'h0001) begin
            cnt  <= 16'h0000;
            kick <= 1'b0;
        end else begin
            cnt <= cnt + 16'h0001;
            if (cnt == {1'b0, gap[15:1]}) kick <= 1'b1;
        end
    end
endmodule : swwd_host
`default_nettype wire

// ---- tb/swwd_top_tb.sv ----
// self-checking bench: supply, manual reset, window kicks and registers
`timescale 1ns/100ps
`default_nettype none
module swwd_top_tb;
    import swwd_pkg::*;
    localparam logic [31:0] HOLD = 32'h0000_0028;
    logic        hclk, hresetn, hsel, hwrite, hrdy, hresp, go, en, req_n;
    logic        sbt, sah, sbm, kick, r_oe, f_oe, chg, r_out_n, f_out_n;
    logic        rpin, fpin, sel;
    logic [1:0]  htrans;
    logic [7:0]  chg_cnt, ramp;
    logic [15:0] gap;
    logic [31:0] haddr, hwdata, hrdata;
    int          n_mismatch, num_checks, cyc;
    // open-drain pins with pull-ups; ramp 0 is a pulled-up select pin,
    // otherwise the pin crosses its threshold ramp cycles into charging
    assign rpin = r_oe ? r_out_n : 1'b1;
    assign fpin = f_oe ? f_out_n : 1'b1;
    assign sel  = (ramp == 8'h00) || (chg && chg_cnt >= ramp);
    always_ff @(posedge hclk) chg_cnt <= chg ? chg_cnt + 8'h01 : 8'h00;
    swwd_top #(.HOLD_CYCLES(HOLD), .LOW_FLOAT(32'h3C), .UP_FLOAT(32'h78),
        .LOW_PULL(32'h14), .UP_PULL(32'h32), .SETTLE_CYCLES(32'h0C),
        .CLS_EVAL(32'h3C), .CLS_FLOAT(32'h0A)) swwd_top_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
        .supply_below_threshold(sbt), .supply_above_hysteresis(sah),
        .supply_below_min(sbm), .manual_reset_request_n(req_n),
        .watchdog_kick_in(kick), .watchdog_enable_pin(en),
        .window_timing_select_pin(sel), .select_charge_en(chg),
        .reset_pin_in(rpin), .reset_out_n(r_out_n), .reset_oe(r_oe),
        .watchdog_fault_pin_in(fpin), .watchdog_fault_out_n(f_out_n),
        .watchdog_fault_oe(f_oe));
    swwd_host swwd_host_inst (.hclk(hclk), .hresetn(hresetn), .go(go),
        .gap(gap), .kick(kick));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk
    task ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hrdy !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hrdy !== 1'b1);
        r = hrdata;
    endtask : ahb
    task wait_while(input bit fs, input logic v, output int n);
        n = 0;
        while ((fs ? f_oe : r_oe) === v && n < 600) begin
            @(posedge hclk);
            n++;
        end
    endtask : wait_while
    task sc_regs;
        logic [31:0] r;
        ahb(1'b0, 32'h4, 32'h0, r);
        chk("cap_upper_rst", CAP_UPPER_RST, r);
        ahb(1'b1, 32'h4, 32'h0000_0100, r);
        ahb(1'b1, 32'h0, 32'hFFFF_FFFF, r);
        ahb(1'b0, 32'h4, 32'h0, r);
        chk("cap_upper", 32'h0000_0100, r);
        ahb(1'b0, 32'hC, 32'h0, r);
        chk("unmapped", 32'h0, r);
        ahb(1'b0, 32'h0, 32'h0, r);
        chk("status", 32'hD4, {24'h0, r[7:0]});
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : sc_regs
    task sc_reset;
        int n;
        for (int c = 0; c < 3; c++) begin
            @(posedge hclk);
            req_n <= (c != 0);
            sbt   <= (c == 1);
            sah   <= (c != 1);
            sbm   <= (c == 2);
            @(posedge hclk);
            #1 chk("reset_pin", 32'h0, {31'h0, rpin});
            repeat (4) @(posedge hclk);
            {req_n, sbt, sah, sbm} <= 4'b1010;
            wait_while(1'b0, 1'b1, n);
            chk("hold_len", 32'h1, {31'h0, n >= HOLD - 1 && n <= HOLD + 3});
        end
    endtask : sc_reset
    task sc_kick;
        int n;
        en <= 1'b1;
        go <= 1'b1;
        wait_while(1'b1, 1'b0, n);
        chk("no_fault", 32'h258, n);
        go  <= 1'b0;
        gap <= 16'h000A;
        @(posedge hclk);
        go <= 1'b1;
        wait_while(1'b1, 1'b0, n);
        chk("early_fault", 32'h1, {31'h0, n < 100});
        chk("fault_pin", 32'h0, {31'h0, fpin});
        go <= 1'b0;
        wait_while(1'b1, 1'b1, n);
        chk("fault_len", 32'h1, {31'h0, n >= HOLD - 1 && n <= HOLD + 1});
        wait_while(1'b1, 1'b0, n);
        chk("late_fault", 32'h1, {31'h0, n >= 48 && n <= 52});
        req_n <= 1'b0;
        @(posedge hclk);
        #1 chk("fault_off", 32'h0, {31'h0, f_oe});
        @(posedge hclk);
        req_n <= 1'b1;
        wait_while(1'b0, 1'b1, n);
        en <= 1'b0;
        wait_while(1'b1, 1'b0, n);
        chk("disabled", 32'h258, n);
    endtask : sc_kick
    task sc_class;
        logic [31:0] r;
        int n;
        for (int c = 0; c < 3; c++) begin
            @(posedge hclk);
            ramp  <= (c == 0) ? 8'hC8 : (c == 1) ? 8'h1E : 8'h03;
            req_n <= 1'b0;
            repeat (4) @(posedge hclk);
            #1 chk("charge_on", 32'h1, {31'h0, chg});
            @(posedge hclk);
            req_n <= 1'b1;
            wait_while(1'b0, 1'b1, n);
            ahb(1'b0, 32'h0, 32'h0, r);
            chk("class_mode", {30'h0, c != 2, 1'b0}, {30'h0, r[3:2]});
        end
        gap <= 16'h005A;
        en  <= 1'b1;
        go  <= 1'b1;
        wait_while(1'b1, 1'b0, n);
        chk("float_window", 32'h258, n);
        ahb(1'b0, 32'h8, 32'h0, r);
        chk("fault_count", 32'h2, r);
    endtask : sc_class
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc > 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    initial begin
        int n;
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {sbt, sbm, go, en, req_n, sah, gap} = {5'h01, 1'b1, 16'h001E};
        ramp = 8'h00;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        wait_while(1'b0, 1'b1, n);
        sc_regs();
        sc_reset();
        sc_kick();
        sc_class();
        finish_test();
    end
endmodule : swwd_top_tb
`default_nettype wire

// ---- verilog/swwd_top.sv ----
// supervisor with window watchdog and AHB-Lite status/control registers
`timescale 1ns/100ps
`default_nettype none
module swwd_top #(
    parameter logic [31:0] HOLD_CYCLES  = 32'(swwd_pkg::RST_HOLD_CYC),
    parameter logic [31:0] LOW_FLOAT    = 32'(swwd_pkg::LOW_FLOAT_CYC),
    parameter logic [31:0] UP_FLOAT     = 32'(swwd_pkg::UP_FLOAT_CYC),
    parameter logic [31:0] LOW_PULL     = 32'(swwd_pkg::LOW_PULL_CYC),
    parameter logic [31:0] UP_PULL      = 32'(swwd_pkg::UP_PULL_CYC),
    parameter logic [31:0] SETTLE_CYCLES = 32'(swwd_pkg::SETTLE_CYC),
    parameter logic [31:0] CLS_EVAL     = 32'(swwd_pkg::CLS_EVAL_CYC),
    parameter logic [31:0] CLS_FLOAT    = 32'(swwd_pkg::CLS_FLOAT_CYC)
) (
    input  wire logic        hclk,                   // bus clock
    input  wire logic        hresetn,                // async reset, low
    input  wire logic        hsel,                   // slave select
    input  wire logic [31:0] haddr,                  // byte address
    input  wire logic [1:0]  htrans,                 // transfer type
    input  wire logic        hwrite,                 // write when high
    input  wire logic [2:0]  hsize,                  // word only
    input  wire logic [31:0] hwdata,                 // write data
    input  wire logic        hready,                 // bus ready
    output logic      [31:0] hrdata,                 // read data
    output logic             hreadyout,              // always ready
    output logic             hresp,                  // always okay
    input  wire logic        supply_below_threshold, // falling comparator
    input  wire logic        supply_above_hysteresis,// rising comparator
    input  wire logic        supply_below_min,       // below operating level
    input  wire logic        manual_reset_request_n, // manual request, low
    input  wire logic        watchdog_kick_in,       // kick input
    input  wire logic        watchdog_enable_pin,    // watchdog enable
    input  wire logic        window_timing_select_pin, // select pin level
    output logic             select_charge_en,       // select pin charge on
    input  wire logic        reset_pin_in,           // reset pin level
    output logic             reset_out_n,            // reset drive value
    output logic             reset_oe,               // reset pulled low
    input  wire logic        watchdog_fault_pin_in,  // fault pin level
    output logic             watchdog_fault_out_n,   // fault drive value
    output logic             watchdog_fault_oe       // fault pulled low
);
    import swwd_pkg::*;

    logic            uv_low;
    logic            cause;
    logic            cause_q;
    logic [31:0]     hold_cnt;
    logic            rst_active;
    swwd_cls_type    cls_state;
    logic [31:0]     cls_cnt;
    swwd_mode_type   mode;
    logic            cls_done;
    logic            wd_allow;
    logic            kick_q;
    logic            kick_fall;
    swwd_wd_type     wd_state;
    logic [31:0]     win_cnt;
    swwd_window_type win;
    logic [31:0]     cap_upper;
    logic [31:0]     fault_count;
    logic            wr_pend;
    logic [11:0]     wr_addr;
    logic            accept;

    // undervoltage latch with hysteresis; starts low as at power-up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            uv_low <= 1'b1;
        end else if (supply_below_threshold) begin
            uv_low <= 1'b1;
        end else if (supply_above_hysteresis) begin
            uv_low <= 1'b0;
        end
    end

    assign cause = uv_low | supply_below_threshold | supply_below_min
                 | !manual_reset_request_n;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_cnt <= 32'h0000_0000;
        end else if (cause) begin
            hold_cnt <= 32'h0000_0000;
        end else if (hold_cnt != HOLD_CYCLES) begin
            hold_cnt <= hold_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_active <= 1'b1;
            cause_q    <= 1'b1;
        end else begin
            rst_active <= cause || (hold_cnt < HOLD_CYCLES - 32'h1)
                       || !cls_done;
            cause_q    <= cause;
        end
    end

    assign reset_out_n = 1'b0;
    assign reset_oe    = rst_active;

    // timing-select classification, rerun on each reset event that starts after it has finished
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cls_state <= CLS_IDLE;
            cls_cnt   <= 32'h0000_0000;
            mode      <= MODE_FLOAT;
        end else begin
            case (cls_state)
                CLS_IDLE: begin
                    cls_cnt <= 32'h0000_0000;
                    if (!supply_below_threshold && !supply_below_min) begin
                        cls_state <= CLS_PROBE;
                    end
                end
                CLS_PROBE: begin
                    if (window_timing_select_pin) begin
                        mode      <= MODE_PULLUP;
                        cls_state <= CLS_DONE;
                    end else begin
                        cls_state <= CLS_CHARGE;
                    end
                end
                CLS_CHARGE: begin
                    cls_cnt <= cls_cnt + 32'h0000_0001;
                    if (window_timing_select_pin) begin
                        mode      <= (cls_cnt < CLS_FLOAT) ? MODE_FLOAT
                                                           : MODE_CAP;
                        cls_state <= CLS_DONE;
                    end else if (cls_cnt >= CLS_EVAL - 32'h2) begin
                        mode      <= MODE_CAP;
                        cls_state <= CLS_DONE;
                    end
                end
                CLS_DONE: begin
                    if (cause && !cause_q) begin
                        cls_state <= CLS_IDLE;
                    end
                end
                default: begin
                    cls_state <= CLS_IDLE;
                end
            endcase
            if (cls_state != CLS_DONE && cls_state != CLS_IDLE
                && (supply_below_threshold || supply_below_min)) begin
                cls_state <= CLS_IDLE;
            end
        end
    end

    assign cls_done      = (cls_state == CLS_DONE);
    assign select_charge_en = (cls_state == CLS_CHARGE);

    // watchdog allowed only with pin high, no manual request, no reset
    assign wd_allow  = watchdog_enable_pin && manual_reset_request_n
                    && !rst_active;
    assign kick_fall = kick_q && !watchdog_kick_in;
    assign win = swwd_window(mode, cap_upper, LOW_FLOAT, UP_FLOAT,
                             LOW_PULL, UP_PULL);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            kick_q <= 1'b1;
        end else begin
            kick_q <= watchdog_kick_in;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wd_state <= WD_OFF;
            win_cnt  <= 32'h0000_0000;
        end else if (!wd_allow) begin
            wd_state <= WD_OFF;
            win_cnt  <= 32'h0000_0000;
        end else begin
            case (wd_state)
                WD_OFF: begin
                    wd_state <= WD_SETUP;
                    win_cnt  <= 32'h0000_0000;
                end
                WD_SETUP: begin
                    win_cnt <= win_cnt + 32'h0000_0001;
                    if (win_cnt >= SETTLE_CYCLES - 32'h1) begin
                        wd_state <= WD_FIRST;
                        win_cnt  <= 32'h0000_0000;
                    end
                end
                WD_FIRST: begin
                    win_cnt <= win_cnt + 32'h0000_0001;
                    if (kick_fall) begin
                        wd_state <= WD_RUN;
                        win_cnt  <= 32'h0000_0000;
                    end else if (win_cnt >= win.upper - 32'h1) begin
                        wd_state <= WD_FAULT;
                        win_cnt  <= 32'h0000_0000;
                    end
                end
                WD_RUN: begin
                    win_cnt <= win_cnt + 32'h0000_0001;
                    if (kick_fall) begin
                        win_cnt <= 32'h0000_0000;
                        if (win_cnt < win.lower) begin
                            wd_state <= WD_FAULT;
                        end
                    end else if (win_cnt >= win.upper - 32'h1) begin
                        wd_state <= WD_FAULT;
                        win_cnt  <= 32'h0000_0000;
                    end
                end
                WD_FAULT: begin
                    win_cnt <= win_cnt + 32'h0000_0001;
                    if (win_cnt >= HOLD_CYCLES - 32'h1) begin
                        wd_state <= WD_FIRST;
                        win_cnt  <= 32'h0000_0000;
                    end
                end
                default: begin
                    wd_state <= WD_OFF;
                end
            endcase
        end
    end

    assign watchdog_fault_out_n = 1'b0;
    assign watchdog_fault_oe    = (wd_state == WD_FAULT)
                               && !rst_active;

    // AHB-Lite slave, zero wait states
    assign accept    = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
        end else begin
            wr_pend <= accept && hwrite;
            wr_addr <= haddr[11:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_upper <= CAP_UPPER_RST;
        end else if (wr_pend && wr_addr == REG_CAP_UPPER) begin
            cap_upper <= hwdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_count <= 32'h0000_0000;
        end else if (wd_allow
                     && (wd_state == WD_FIRST || wd_state == WD_RUN)
                     && ((!kick_fall && win_cnt >= win.upper - 32'h1)
                         || (kick_fall && wd_state == WD_RUN
                             && win_cnt < win.lower))) begin
            // a kick on the last window cycle wins over the timeout
            fault_count <= fault_count + 32'h0000_0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else begin
            hrdata <= 32'h0000_0000;
            if (accept && !hwrite) begin
                case (haddr[11:0])
                    REG_STATUS: begin
                        hrdata[ST_RESET_BIT] <= rst_active;
                        hrdata[ST_FAULT_BIT] <= watchdog_fault_oe;
                        hrdata[ST_MODE_LSB +: 2] <= mode;
                        hrdata[ST_CLS_BIT]   <= cls_done;
                        hrdata[ST_RUN_BIT]   <= (wd_state == WD_FIRST)
                                             || (wd_state == WD_RUN);
                        hrdata[ST_RPIN_BIT]  <= reset_pin_in;
                        hrdata[ST_FPIN_BIT]  <= watchdog_fault_pin_in;
                    end
                    REG_CAP_UPPER:   hrdata <= cap_upper;
                    REG_FAULT_COUNT: hrdata <= fault_count;
                    default:         hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // helper state read only by the checks below
    logic [31:0] quiet_cnt;
    logic [31:0] flen;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quiet_cnt <= 32'h0000_0000;
            flen      <= 32'h0000_0000;
        end else begin
            quiet_cnt <= cause ? 32'h0000_0000
                       : (quiet_cnt == HOLD_CYCLES) ? quiet_cnt
                       : quiet_cnt + 32'h0000_0001;
            flen      <= watchdog_fault_oe ? flen + 32'h0000_0001
                                           : 32'h0000_0000;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_enable_edge;
        $rose(wd_allow);
    endsequence
    sequence s_enable_held;
        wd_allow[*8];
    endsequence

    property p_uv_reset;
        supply_below_threshold |=> reset_oe;
    endproperty
    a_uv_reset: assert property (p_uv_reset)
        else $error("reset not asserted on undervoltage");

    property p_hold_release;
        $fell(reset_oe) |-> quiet_cnt >= HOLD_CYCLES;
    endproperty
    a_hold_release: assert property (p_hold_release)
        else $error("reset released before hold period");

    property p_manual_reset;
        !manual_reset_request_n |=> reset_oe && !watchdog_fault_oe;
    endproperty
    a_manual_reset: assert property (p_manual_reset)
        else $error("manual request did not assert reset");

    property p_disable;
        !watchdog_enable_pin |=> !watchdog_fault_oe && wd_state == WD_OFF;
    endproperty
    a_disable: assert property (p_disable)
        else $error("watchdog active while disabled");

    property p_settle;
        s_enable_edge ##1 s_enable_held |-> wd_state == WD_SETUP;
    endproperty
    a_settle: assert property (p_settle)
        else $error("kicks not ignored during settle");

    property p_rise_ignored;
        wd_state == WD_RUN && wd_allow && !kick_q && watchdog_kick_in
        && win_cnt < win.upper - 32'h1 |=> win_cnt == $past(win_cnt) + 32'h1;
    endproperty
    a_rise_ignored: assert property (p_rise_ignored)
        else $error("rising kick edge disturbed the window");

    property p_early_kick;
        wd_state == WD_RUN && wd_allow && kick_fall && win_cnt < win.lower
        |=> wd_state == WD_FAULT;
    endproperty
    a_early_kick: assert property (p_early_kick)
        else $error("early kick did not raise fault");

    property p_first_timeout;
        wd_state == WD_FIRST && wd_allow && !kick_fall
        && win_cnt == win.upper - 32'h1 |=> wd_state == WD_FAULT;
    endproperty
    a_first_timeout: assert property (p_first_timeout)
        else $error("missing first kick did not raise fault");

    property p_fault_hiz;
        reset_oe |-> !watchdog_fault_oe ##1 wd_state == WD_OFF;
    endproperty
    a_fault_hiz: assert property (p_fault_hiz)
        else $error("fault driven during reset");

    property p_fault_len;
        $fell(watchdog_fault_oe) && $past(wd_allow) && wd_allow
        |-> flen == HOLD_CYCLES;
    endproperty
    a_fault_len: assert property (p_fault_len)
        else $error("fault pulse length wrong");

    property p_cls_bound;
        cls_state == CLS_CHARGE |-> cls_cnt < CLS_EVAL;
    endproperty
    a_cls_bound: assert property (p_cls_bound)
        else $error("classification too long");

    property p_pullup_class;
        cls_state == CLS_PROBE && window_timing_select_pin
        && !supply_below_threshold && !supply_below_min
        |=> mode == MODE_PULLUP && cls_done;
    endproperty
    a_pullup_class: assert property (p_pullup_class)
        else $error("pulled-up select pin misclassified");

endmodule : swwd_top
`default_nettype wire
